/* File: rtl/fcw_decoder.sv */
// Functional notes
// - Ramp stop bit low: ramp down, then ready
// - Coast stop bit low: coast, then inhibited
// - Fast stop bit low: fast stop, then inhibited
// - Operate bit low: operation inhibited
// - Operate bit drives run enable from fieldbus
// - Ramp output bit low forces output zero
// - Ramp run bit low holds ramp output
// - Ramp input bit low forces input zero
// - Reset bit rising edge clears fault
// - Jog 1 bit runs jog setpoint 1
// - Jog 2 bit runs jog setpoint 2
// - Remote gate low passes only stop bits
// - Location bit selects external location b
`default_nettype none

module fcw_decoder
   import fcw_pkg::*;
#(
   parameter int unsigned WORD_W = FCW_WORD_W           // Command word width
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              word_valid,           // Adapter strobe, one cycle
   input  wire logic [WORD_W-1:0] fieldbus_command_word,
   input  wire fcw_cfg_s          cfg,                  // Source selections
   input  wire logic              run_enable_ext,       // Run enable from other source
   input  wire logic              ramp_in_ext,          // Ramp input enable, other source
   input  wire logic              reset_ext,            // Fault reset pulse, other source
   input  wire logic              location_ext,         // Location select, other source
   input  wire logic              fault_active,         // Drive core has a fault
   input  wire logic              motor_stopped,        // Speed reached zero
   output fcw_state_e             drive_state,          // Current drive state
   output logic                   run_enable,           // Effective run enable
   output logic                   fault_reset,          // One-cycle fault reset
   output fcw_ctrl_s              ctrl                  // Ramp and setpoint controls
);

   // Elaboration check: the bit positions are fixed for a 16-bit word
   if (WORD_W != FCW_WORD_W) begin : g_bad_width
      $error("fcw_decoder: word width must be 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command word latch
   logic [WORD_W-1:0] w;                                // Accepted word
   logic              w_rise;                           // Reset bit edge

   fcw_word_latch #(.WORD_W(WORD_W)) u_latch (
      .clock      (clock),
      .rst_n      (rst_n),
      .word_valid (word_valid),
      .word_in    (fieldbus_command_word),
      .word       (w),
      .reset_rise (w_rise)
   );

   // All state of the decoder
   typedef struct packed {
      fcw_state_e state;                                // Drive state
      logic       run_en;                               // Registered run enable
      logic       freset;                               // Registered reset pulse
      fcw_ctrl_s  ctrl;                                 // Registered controls
   } fcw_dec_s;

   fcw_dec_s st;                                        // Registered state
   fcw_dec_s next_st;                                   // Next state

   // Source multiplexer shared by the selectable signals
   function automatic logic pick(input logic use_fb, input logic fb, input logic ext);
      pick = use_fb ? fb : ext;
   endfunction

   logic run_ok;                                        // Effective run enable, operate bit or other source
   logic ramp_in_en;                                    // Effective ramp input enable
   logic reset_req;                                     // Effective reset request
   logic stops_clear;                                   // Coast and fast bits both high
   logic jog_ok;                                        // Ramp output, run and input bits all zero

   ////////////////////////////////////////////////////////////////////////////
   // Source selection
   always_comb begin
      run_ok      = pick(cfg.run_enable_fb, w[FCW_B_OPERATE], run_enable_ext);
      ramp_in_en  = pick(cfg.ramp_in_fb, w[FCW_B_RAMP_IN], ramp_in_ext);
      reset_req   = pick(cfg.reset_fb, w_rise, reset_ext);
      stops_clear = w[FCW_B_COAST_STOP] & w[FCW_B_FAST_STOP];
      jog_ok      = (w[FCW_B_RAMP_IN:FCW_B_RAMP_OUT] == 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State transitions and controls
   always_comb begin
      next_st        = st;
      next_st.run_en = run_ok;
      next_st.freset = 1'b0;
      // Priority: fault, coast, fast, then the normal sequence
      if (st.state == FCW_ST_FAULT) begin
         if (reset_req) begin
            next_st.state  = FCW_ST_SWITCH_ON_INHIBIT;
            next_st.freset = 1'b1;
         end
      end else if (fault_active) begin
         next_st.state = FCW_ST_FAULT;
      end else if (!w[FCW_B_COAST_STOP] && st.state != FCW_ST_SWITCH_ON_INHIBIT) begin
         // Coast wins over fast: torque is removed at once
         next_st.state = (st.state == FCW_ST_COAST_STOP && motor_stopped) ?
                         FCW_ST_SWITCH_ON_INHIBIT : FCW_ST_COAST_STOP;
      end else if (!w[FCW_B_FAST_STOP] && st.state != FCW_ST_SWITCH_ON_INHIBIT &&
                   st.state != FCW_ST_COAST_STOP) begin
         // A coast already running ends inhibited; fast stop cannot take it over
         next_st.state = (st.state == FCW_ST_FAST_STOP && motor_stopped) ?
                         FCW_ST_SWITCH_ON_INHIBIT : FCW_ST_FAST_STOP;
      end else begin
         case (st.state)
            FCW_ST_SWITCH_ON_INHIBIT: begin
               // Leaving needs stops released and the ramp bit low first
               if (stops_clear && !w[FCW_B_RAMP_STOP]) begin
                  next_st.state = FCW_ST_READY_SWITCH_ON;
               end
            end
            FCW_ST_READY_SWITCH_ON: begin
               if (w[FCW_B_RAMP_STOP]) begin
                  next_st.state = FCW_ST_READY_OPERATE;
               end
            end
            FCW_ST_READY_OPERATE: begin
               if (!w[FCW_B_RAMP_STOP]) begin
                  next_st.state = FCW_ST_READY_SWITCH_ON;
               end else if (w[FCW_B_OPERATE] && run_ok) begin
                  next_st.state = FCW_ST_OPERATING;
               end
            end
            FCW_ST_OPERATING: begin
               if (!w[FCW_B_RAMP_STOP]) begin
                  next_st.state = FCW_ST_RAMP_STOP;
               end else if (!w[FCW_B_OPERATE] || !run_ok) begin
                  next_st.state = FCW_ST_READY_OPERATE;
               end
            end
            FCW_ST_RAMP_STOP: begin
               // Stop completes even if the ramp bit returns mid-ramp
               if (motor_stopped) begin
                  next_st.state = FCW_ST_READY_SWITCH_ON;
               end
            end
            FCW_ST_COAST_STOP,
            FCW_ST_FAST_STOP: begin
               // Stop bit released before standstill: still end inhibited
               if (motor_stopped) begin
                  next_st.state = FCW_ST_SWITCH_ON_INHIBIT;
               end
            end
            default: begin
               next_st.state = FCW_ST_SWITCH_ON_INHIBIT;
            end
         endcase
      end

      // Ramp controls follow the word only while operating
      if (st.state == FCW_ST_OPERATING) begin
         next_st.ctrl.ramp_out_zero = !w[FCW_B_RAMP_OUT];
         next_st.ctrl.ramp_hold     = !w[FCW_B_RAMP_RUN];
         next_st.ctrl.ramp_in_zero  = !ramp_in_en;
      end else begin
         // Ramp stop and fast stop decelerate; other states keep the ramp at zero
         next_st.ctrl.ramp_out_zero = (st.state != FCW_ST_RAMP_STOP) &&
                                      (st.state != FCW_ST_FAST_STOP);
         next_st.ctrl.ramp_hold     = 1'b0;
         next_st.ctrl.ramp_in_zero  = 1'b1;
      end
      next_st.ctrl.jog1 = w[FCW_B_JOG1] && jog_ok && stops_clear &&
                          (st.state == FCW_ST_READY_OPERATE);
      next_st.ctrl.jog2 = w[FCW_B_JOG2] && jog_ok && stops_clear &&
                          (st.state == FCW_ST_READY_OPERATE);
      next_st.ctrl.coast     = (next_st.state == FCW_ST_COAST_STOP);
      next_st.ctrl.fast_ramp = (next_st.state == FCW_ST_FAST_STOP);
      next_st.ctrl.external_location_b =
         pick(cfg.location_fb, w[FCW_B_LOC], location_ext);
      next_st.ctrl.user_bits = w[WORD_W-1:FCW_B_USER_LO];
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st.state <= FCW_ST_SWITCH_ON_INHIBIT;
         st.run_en <= 1'b0;
         st.freset <= 1'b0;
         st.ctrl   <= '{ramp_out_zero: 1'b1, ramp_in_zero: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign drive_state = st.state;
   assign run_enable  = st.run_en;
   assign fault_reset = st.freset;
   assign ctrl        = st.ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_ramp_stop_enter: assert property (
      (drive_state == FCW_ST_OPERATING && !w[FCW_B_RAMP_STOP] && stops_clear
       && !fault_active) |=> drive_state == FCW_ST_RAMP_STOP)
      else $error("Ramp stop not entered");

   a_ramp_stop_exit: assert property (
      (drive_state == FCW_ST_RAMP_STOP && motor_stopped && stops_clear
       && !fault_active) |=> drive_state == FCW_ST_READY_SWITCH_ON)
      else $error("Ramp stop did not end in ready to switch on");

   a_coast_path: assert property (
      (drive_state == FCW_ST_COAST_STOP && motor_stopped && !fault_active)
      |=> drive_state == FCW_ST_SWITCH_ON_INHIBIT ##0 !ctrl.coast)
      else $error("Coast stop did not end inhibited");

   a_coast_enter: assert property (
      (!w[FCW_B_COAST_STOP] && !fault_active && drive_state == FCW_ST_OPERATING)
      |=> drive_state == FCW_ST_COAST_STOP && ctrl.coast)
      else $error("Coast stop not entered");

   a_fast_enter: assert property (
      (w[FCW_B_COAST_STOP] && !w[FCW_B_FAST_STOP] && !fault_active
       && drive_state == FCW_ST_OPERATING)
      |=> drive_state == FCW_ST_FAST_STOP && ctrl.fast_ramp)
      else $error("Fast stop not entered");

   a_op_inhibit: assert property (
      (drive_state == FCW_ST_OPERATING && w[FCW_B_RAMP_STOP] && stops_clear
       && !fault_active && !w[FCW_B_OPERATE]) |=> drive_state == FCW_ST_READY_OPERATE)
      else $error("Operation not inhibited");

   a_run_enable_fb: assert property (cfg.run_enable_fb |=>
      run_enable == $past(w[FCW_B_OPERATE]))
      else $error("Run enable does not follow operate bit");

   a_ramp_out_zero: assert property (
      drive_state == FCW_ST_OPERATING |=> ctrl.ramp_out_zero == !$past(w[FCW_B_RAMP_OUT]))
      else $error("Ramp output zero wrong");

   a_ramp_hold: assert property (
      drive_state == FCW_ST_OPERATING |=> ctrl.ramp_hold == !$past(w[FCW_B_RAMP_RUN]))
      else $error("Ramp hold wrong");

   a_ramp_in_zero: assert property (
      (drive_state == FCW_ST_OPERATING && cfg.ramp_in_fb)
      |=> ctrl.ramp_in_zero == !$past(w[FCW_B_RAMP_IN]))
      else $error("Ramp input zero wrong");

   a_fault_reset: assert property (
      (drive_state == FCW_ST_FAULT && cfg.reset_fb && w_rise)
      |=> fault_reset && drive_state == FCW_ST_SWITCH_ON_INHIBIT ##1 !fault_reset)
      else $error("Fault reset not taken once");

   a_jog_gate: assert property ((ctrl.jog1 || ctrl.jog2) |->
      $past(jog_ok) && $past(drive_state) == FCW_ST_READY_OPERATE)
      else $error("Jog without its conditions");

   a_location: assert property (cfg.location_fb |=>
      ctrl.external_location_b == $past(w[FCW_B_LOC]))
      else $error("Location select wrong");

   a_user_bits: assert property (
      ##1 ctrl.user_bits == $past(w[WORD_W-1:FCW_B_USER_LO]))
      else $error("User bits not passed");

   c_ramp_stop:  cover property (drive_state == FCW_ST_OPERATING ##1
                                 drive_state == FCW_ST_RAMP_STOP);
   c_coast_stop: cover property (drive_state == FCW_ST_COAST_STOP ##[1:20]
                                 drive_state == FCW_ST_SWITCH_ON_INHIBIT);
   c_fault_clr:  cover property (drive_state == FCW_ST_FAULT ##1 fault_reset);
   c_jog:        cover property (ctrl.jog1);

endmodule

`default_nettype wire

/* File: rtl/fcw_pkg.sv */
`default_nettype none

package fcw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Command word geometry
   localparam int unsigned FCW_WORD_W   = 16;           // Width of the command word
   localparam int unsigned FCW_USER_W   = 4;            // Width of the user field

   // Bit positions inside the command word
   localparam int unsigned FCW_B_RAMP_STOP  = 0;        // Ramp stop bit, low active
   localparam int unsigned FCW_B_COAST_STOP = 1;        // Coast stop bit, low active
   localparam int unsigned FCW_B_FAST_STOP  = 2;        // Fast stop bit, low active
   localparam int unsigned FCW_B_OPERATE    = 3;        // Operation enable
   localparam int unsigned FCW_B_RAMP_OUT   = 4;        // Ramp output enable
   localparam int unsigned FCW_B_RAMP_RUN   = 5;        // Ramp running, low holds
   localparam int unsigned FCW_B_RAMP_IN    = 6;        // Ramp input enable
   localparam int unsigned FCW_B_RESET      = 7;        // Fault reset, rising edge
   localparam int unsigned FCW_B_JOG1       = 8;        // Jog setpoint 1
   localparam int unsigned FCW_B_JOG2       = 9;        // Jog setpoint 2
   localparam int unsigned FCW_B_REMOTE     = 10;       // Remote accept gate
   localparam int unsigned FCW_B_LOC        = 11;       // Location select
   localparam int unsigned FCW_B_USER_LO    = 12;       // Lowest user bit

   // Bits that pass even while the remote gate is closed
   localparam int unsigned FCW_STOP_BITS    = 3;

   // Reset value of the held command word: all stops asserted, nothing runs
   localparam logic [15:0] FCW_WORD_RST     = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Drive states
   typedef enum logic [2:0] {
      FCW_ST_SWITCH_ON_INHIBIT,
      FCW_ST_READY_SWITCH_ON,
      FCW_ST_READY_OPERATE,
      FCW_ST_OPERATING,
      FCW_ST_RAMP_STOP,
      FCW_ST_COAST_STOP,
      FCW_ST_FAST_STOP,
      FCW_ST_FAULT
   } fcw_state_e;

   // Source selection: high means the fieldbus word is the source
   typedef struct packed {
      logic run_enable_fb;                              // Run enable source
      logic ramp_in_fb;                                 // Ramp input source
      logic reset_fb;                                   // Fault reset source
      logic location_fb;                                // Location select source
   } fcw_cfg_s;

   // Ramp generator and setpoint controls driven to the drive core
   typedef struct packed {
      logic                  ramp_out_zero;             // Force ramp output to zero
      logic                  ramp_hold;                 // Freeze ramp output
      logic                  ramp_in_zero;              // Force ramp input to zero
      logic                  jog1;                      // Run to jog setpoint 1
      logic                  jog2;                      // Run to jog setpoint 2
      logic                  coast;                     // Remove torque, coast
      logic                  fast_ramp;                 // Use emergency decel time
      logic                  external_location_b;       // High selects location b
      logic [FCW_USER_W-1:0] user_bits;                 // Pass-through user bits
   } fcw_ctrl_s;

endpackage

`default_nettype wire

/* File: rtl/fcw_word_latch.sv */
`default_nettype none

module fcw_word_latch
   import fcw_pkg::*;
#(
   parameter int unsigned WORD_W = FCW_WORD_W           // Command word width
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              word_valid,           // New word from the adapter
   input  wire logic [WORD_W-1:0] word_in,              // Raw command word
   output logic      [WORD_W-1:0] word,                 // Accepted word
   output logic                   reset_rise            // One-cycle reset edge
);

   // Elaboration check: the bit positions are fixed for a 16-bit word
   if (WORD_W != FCW_WORD_W) begin : g_bad_width
      $error("fcw_word_latch: word width must be 16");
   end

   // All state of the latch
   typedef struct packed {
      logic [WORD_W-1:0] word;                          // Accepted word
      logic              rise;                          // Reset edge pulse
   } fcw_latch_s;

   fcw_latch_s st;                                      // Registered state
   fcw_latch_s next_st;                                 // Next state

   logic [WORD_W-1:0] merged;                           // Word after remote gating

   ////////////////////////////////////////////////////////////////////////////
   // Merge and edge evaluation
   always_comb begin
      next_st      = st;
      next_st.rise = 1'b0;
      merged       = word_in;
      // Closed gate keeps the old word except the stop bits
      if (!word_in[FCW_B_REMOTE]) begin
         merged = {st.word[WORD_W-1:FCW_STOP_BITS], word_in[FCW_STOP_BITS-1:0]};
      end
      if (word_valid) begin
         next_st.word = merged;
         // Compared with the previous word so one edge gives one pulse
         next_st.rise = merged[FCW_B_RESET] & ~st.word[FCW_B_RESET];
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{word: FCW_WORD_RST, rise: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign word       = st.word;
   assign reset_rise = st.rise;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_stop_bits_pass: assert property (word_valid |=>
      word[FCW_STOP_BITS-1:0] == $past(word_in[FCW_STOP_BITS-1:0]))
      else $error("Stop bits not taken from new word");

   a_gate_holds: assert property ((word_valid && !word_in[FCW_B_REMOTE]) |=>
      word[WORD_W-1:FCW_STOP_BITS] == $past(word[WORD_W-1:FCW_STOP_BITS]))
      else $error("Gated word bits changed");

   a_one_pulse: assert property (reset_rise |=> !reset_rise)
      else $error("Reset edge lasted more than one cycle");

endmodule

`default_nettype wire

/* File: tb/fcw_master_model.sv */
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Remote master seen through the adapter: one strobed word at a time
module fcw_master_model (
   input  wire logic        clock,
   output var  logic        word_valid,           // One-cycle word strobe
   output var  logic [15:0] word                  // Command word to the drive
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle: no strobe, bus shows a pattern the drive must not trust
   initial begin
      word_valid = 1'b0;
      word       = 16'hffff;
   end

   // Present one word for exactly one rising edge, then release it
   task automatic send(input logic [15:0] w);
      @(negedge clock);
      word_valid <= 1'b1;
      word       <= w;
      @(negedge clock);
      word_valid <= 1'b0;
      word       <= ~w;                            // Released: stale value inverted
   endtask
endmodule

`default_nettype wire

/* File: tb/fieldbus_command_word_decoder_tb.sv */
`default_nettype none

module fieldbus_command_word_decoder_tb
   import fcw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clock = 1'b0;                      // 50 MHz system clock
   logic        rst_n = 1'b0;                      // Async reset, low active
   logic        word_valid;                        // From master model
   logic [15:0] word;                              // From master model
   fcw_cfg_s    cfg = 4'hf;                        // Fieldbus is every source
   logic        run_enable_ext = 1'b0;
   logic        ramp_in_ext = 1'b0;
   logic        reset_ext = 1'b0;
   logic        location_ext = 1'b0;
   logic        fault_active = 1'b0;
   logic        motor_stopped = 1'b0;
   fcw_state_e  drive_state;
   logic        run_enable;
   logic        fault_reset;
   fcw_ctrl_s   ctrl;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n;
   logic [15:0] tw [3] = '{16'hf46f, 16'hf45f, 16'hf43f};  // One ramp bit low each
   logic [2:0]  te [3] = '{3'b100, 3'b010, 3'b001};        // Out zero, hold, in zero

   ////////////////////////////////////////////////////////////////////////////
   // Clock, master and design
   always #10 clock = ~clock;

   fcw_master_model i_master (.clock(clock), .word_valid(word_valid), .word(word));

   fcw_decoder i_dut (
      .clock(clock), .rst_n(rst_n), .word_valid(word_valid),
      .fieldbus_command_word(word), .cfg(cfg), .run_enable_ext(run_enable_ext),
      .ramp_in_ext(ramp_in_ext), .reset_ext(reset_ext), .location_ext(location_ext),
      .fault_active(fault_active), .motor_stopped(motor_stopped),
      .drive_state(drive_state), .run_enable(run_enable), .fault_reset(fault_reset),
      .ctrl(ctrl)
   );

   // Hang guard: whole run needs well under two hundred cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare, wait and send helpers
   task automatic chk_st(input fcw_state_e exp);
      samples_checked++;
      if (drive_state !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t state got %h exp %h", $time, drive_state, exp);
      end
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t value got %h exp %h", $time, got, exp);
      end
   endtask

   // States move on their own after a word, so poll a bounded while
   task automatic wait_st(input fcw_state_e exp);
      for (int i = 0; i < 8 && drive_state !== exp; i++) @(negedge clock);
      chk_st(exp);
   endtask

   // Answer lands one edge after the word edge; allow two spare
   task automatic send(input logic [15:0] w);
      i_master.send(w);
      repeat (3) @(negedge clock);
   endtask

   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(negedge clock);
      chk_st(FCW_ST_SWITCH_ON_INHIBIT);
      chk_val({2'b00, run_enable, fault_reset, ctrl}, 16'h0a00);
      rst_n = 1'b1;
      // Climb to operation
      send(16'h0406); wait_st(FCW_ST_READY_SWITCH_ON);
      send(16'h0407); wait_st(FCW_ST_READY_OPERATE);
      send(16'h040f); wait_st(FCW_ST_OPERATING);
      chk_val({15'h0, run_enable}, 16'h0001);
      send(16'hfc7f);
      chk_val({11'h0, ctrl.external_location_b, ctrl.user_bits}, 16'h001f);
      chk_val({13'h0, ctrl.ramp_out_zero, ctrl.ramp_hold, ctrl.ramp_in_zero}, 16'h0);
      // Each ramp control bit dropped in turn
      for (int k = 0; k < 3; k++) begin
         send(tw[k]);
         chk_val({13'h0, ctrl.ramp_out_zero, ctrl.ramp_hold, ctrl.ramp_in_zero},
                 {13'h0, te[k]});
      end
      // Gate closed: upper bits ignored, stop bits still act
      send(16'h0007);
      chk_val({12'h0, ctrl.user_bits}, 16'h000f);
      chk_st(FCW_ST_OPERATING);
      send(16'h0006); wait_st(FCW_ST_RAMP_STOP);
      motor_stopped = 1'b1;
      wait_st(FCW_ST_READY_SWITCH_ON);
      // Jog setpoints and operation inhibit
      send(16'h0407); wait_st(FCW_ST_READY_OPERATE);
      send(16'h0507);
      chk_val({14'h0, ctrl.jog1, ctrl.jog2}, 16'h0002);
      send(16'h0607);
      chk_val({14'h0, ctrl.jog1, ctrl.jog2}, 16'h0001);
      send(16'h040f); wait_st(FCW_ST_OPERATING);
      send(16'h0407); wait_st(FCW_ST_READY_OPERATE);
      chk_val({15'h0, run_enable}, 16'h0000);
      // Coast stop, then fast stop
      motor_stopped = 1'b0;
      send(16'h0405); wait_st(FCW_ST_COAST_STOP);
      chk_val({15'h0, ctrl.coast}, 16'h0001);
      motor_stopped = 1'b1;
      wait_st(FCW_ST_SWITCH_ON_INHIBIT);
      send(16'h0406); wait_st(FCW_ST_READY_SWITCH_ON);
      motor_stopped = 1'b0;
      send(16'h0403); wait_st(FCW_ST_FAST_STOP);
      chk_val({15'h0, ctrl.fast_ramp}, 16'h0001);
      motor_stopped = 1'b1;
      wait_st(FCW_ST_SWITCH_ON_INHIBIT);
      // Fault cleared by one rising edge of the reset bit
      fault_active = 1'b1;
      wait_st(FCW_ST_FAULT);
      fault_active = 1'b0;
      n = 0;
      fork
         i_master.send(16'h0486);
         repeat (6) @(negedge clock) begin
            if (fault_reset === 1'b1) begin
               n++;
               chk_st(FCW_ST_SWITCH_ON_INHIBIT);
            end
         end
      join
      chk_val(16'(n), 16'h0001);
      // Other sources selected: fieldbus bits must be refused
      cfg = 4'h0;
      location_ext = 1'b1;
      fault_active = 1'b1;
      wait_st(FCW_ST_FAULT);
      fault_active = 1'b0;
      send(16'h0406);
      send(16'h048e);
      chk_st(FCW_ST_FAULT);
      chk_val({14'h0, run_enable, ctrl.external_location_b}, 16'h0001);
      reset_ext = 1'b1;
      @(negedge clock);
      reset_ext = 1'b0;
      chk_val({15'h0, fault_reset}, 16'h0001);
      wait_st(FCW_ST_SWITCH_ON_INHIBIT);
      end_of_test();
   end
endmodule

`default_nettype wire
